// >>> psf_host.sv
// host model driving word commands into the register block
`default_nettype none
module psf_host
   import psf_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // command port
   output var psf_cmd_t cmd,
   input wire psf_resp_t resp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cmd = '0;
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
      output logic [1:0] ack, output logic [15:0] rd);
      @(posedge sys_clk);
      cmd <= '{1'h1, wr, code, wd};
      @(posedge sys_clk);
      // released fields are inverted so a stale request never looks valid
      cmd <= '{1'h0, ~wr, ~code, ~wd};
      @(posedge sys_clk);
      ack = {resp.valid, resp.ack};
      rd = resp.rdata;
   endtask
endmodule
`default_nettype wire

// >>> psf_pkg.sv
// package: command codes, field layouts and types of the status and fall-time block
`default_nettype none
package psf_pkg;
   // command codes
   localparam logic [7:0] PSF_CMD_FALL_TIME = 8'h65;
   localparam logic [7:0] PSF_CMD_SUM_BYTE = 8'h78;
   localparam logic [7:0] PSF_CMD_SUM_WORD = 8'h79;
   // fall-time word layout (linear format)
   localparam int PSF_EXP_LSB = 11;
   localparam int PSF_MANT_W = 7;
   localparam logic [6:0] PSF_MANT_RESET = 7'h03;
   localparam logic [4:0] PSF_EXP_FIXED = 5'h00;
   localparam logic [3:0] PSF_MANT_HI_FIXED = 4'h0;
   // detailed status bit positions
   localparam int PSF_VOUT_OV_FAULT = 7;
   localparam int PSF_VOUT_OV_WARN = 6;
   localparam int PSF_VOUT_UV_WARN = 5;
   localparam int PSF_VOUT_UV_FAULT = 4;
   localparam int PSF_VOUT_LIM = 3;
   localparam int PSF_VOUT_TONMAX = 2;
   localparam int PSF_IOUT_OC_FAULT = 7;
   localparam int PSF_IOUT_OC_WARN = 5;
   localparam int PSF_INPUT_LOW = 3;
   localparam int PSF_TEMP_OTF = 7;
   localparam int PSF_TEMP_OTW = 6;
   // reset values
   localparam logic PSF_PNG_MASK_RESET = 1'b1;

   // detailed status sources, held outside this block
   typedef struct packed {
      logic [7:0] vout;
      logic [7:0] iout;
      logic [7:0] input_st;
      logic [7:0] temp;
      logic [7:0] comm;
      logic bandgap_overtemp_flag;
      logic internal_supply_flag;
   } psf_detail_t;

   // command request from the bus front end
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [15:0] wdata;
   } psf_cmd_t;

   // command answer
   typedef struct packed {
      logic valid;
      logic ack;
      logic [15:0] rdata;
   } psf_resp_t;

   typedef struct packed {
      logic converter_off;
      logic overvoltage_fault_flag;
      logic overcurrent_fault_flag;
      logic temperature_alarm_flag;
      logic comm_logic_fault_flag;
      logic other_flag;
   } psf_byte_bits_t;
endpackage
`default_nettype wire

// >>> psf_regs.sv
// status summary and output fall-time registers
`default_nettype none

// Functional notes
// - fall-time setting lives at command 65h, end of turn-off delay to 0 V
// - programmed zero gives the fastest ramp, an active 1 ms ramp down
// - loop slave: fall-time access NACKed, data dropped, invalid command, alert
// - store-all-defaults copies the fall-time word to nonvolatile storage
// - exponent reads zero (1 ms units) and writes never change it
// - mantissa upper four bits zero, lower seven writable, reset value 3
// - quantise: <=1 gives 1, 2..6 themselves, 7..9 gives 7, 10..12 gives 10
// - further buckets 14,19,27,37,52,72 ms; above 86 gives 100 ms
// - 78h: b6 off, b5 ov, b4 oc, b2 temp, b1 comm, b0 other, rest zero
// - converter-off bit is one whenever the converter is not enabled
// - overvoltage bit mirrors vout bit 7; zero in a loop slave
// - overcurrent bit mirrors iout bit 7
// - summary bits are never cleared by writes, only via their sources
// - temperature bit set while the overtemperature fault (bit 7) or warning (bit 6) is set
// - communication bit set while any comm-logic status bit is set
// - other bit from uv fault, warnings, timeout, low input, limit, vendor flags
// - 79h word, low byte equals the 78h byte
// - word bit 15: OR of vout faults, warnings, limit warning, timeout
// - word bit 14: OR of overcurrent fault and warning
// - word bit 13: any input fault; bit 12: bandgap or internal supply flag
// - word bit 11 power-not-good is unlatched and tracks present state
// - power-not-good mask resets to one; no power-not-good alert before first power good
// - detailed source bits clear by host write, nv copy acts as alert mask
// - low input set at power-up; only events after first vin-on alert
module psf_regs
   import psf_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // command port
   input wire psf_cmd_t cmd,
   output var psf_resp_t resp,
   // configuration and detailed status
   input wire logic loop_slave,
   input wire logic converter_enabled,
   input wire logic power_good,
   input wire psf_detail_t detail,
   input wire logic src_alert,
   input wire logic vin_above_on,
   input wire logic vin_below_off,
   // power-not-good mask load
   input wire logic png_mask_wr,
   input wire logic png_mask_val,
   // nonvolatile store
   input wire logic store_all,
   output logic nv_store_valid,
   output logic [15:0] nv_fall_time,
   // events and effective fall time
   output logic invalid_command_fault,
   output logic alert_event,
   output logic [6:0] eff_fall_ms
);

   typedef struct packed {
      psf_resp_t resp;
      logic [PSF_MANT_W-1:0] mant;
      logic nv_valid;
      logic [15:0] nv_word;
      logic bad_cmd;
      logic alert;
      logic [6:0] eff_ms;
      logic png_mask;
      logic pg_seen;
      logic png_prev;
      logic vin_seen;
      logic below_prev;
      logic src_prev;
   } psf_state_t;

   psf_state_t st;
   psf_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [6:0] quantise(input logic [6:0] m);
      logic [6:0] ms;
      ms = 7'h64;
      if (m <= 7'h01) begin
         ms = 7'h01;
      end else if (m <= 7'h06) begin
         ms = m;
      end else if (m <= 7'h09) begin
         ms = 7'h07;
      end else if (m <= 7'h0C) begin
         ms = 7'h0A;
      end else if (m <= 7'h11) begin
         ms = 7'h0E;
      end else if (m <= 7'h16) begin
         ms = 7'h13;
      end else if (m <= 7'h20) begin
         ms = 7'h1B;
      end else if (m <= 7'h2C) begin
         ms = 7'h25;
      end else if (m <= 7'h3E) begin
         ms = 7'h34;
      end else if (m <= 7'h56) begin
         ms = 7'h48;
      end
      return ms;
   endfunction

   function automatic logic [15:0] fall_word(input logic [6:0] m);
      return {PSF_EXP_FIXED, PSF_MANT_HI_FIXED, m};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // summary decode, purely combinational from the sources

   psf_byte_bits_t bb;
   logic [7:0] sum_byte;
   logic [7:0] sum_hi;
   logic png_now;

   always_comb begin
      bb.converter_off = ~converter_enabled;
      bb.overvoltage_fault_flag = loop_slave ? 1'b0 : detail.vout[PSF_VOUT_OV_FAULT];
      bb.overcurrent_fault_flag = detail.iout[PSF_IOUT_OC_FAULT];
      bb.temperature_alarm_flag = detail.temp[PSF_TEMP_OTF] | detail.temp[PSF_TEMP_OTW];
      bb.comm_logic_fault_flag = |detail.comm;
      bb.other_flag = detail.vout[PSF_VOUT_UV_FAULT] | detail.iout[PSF_IOUT_OC_WARN]
         | detail.vout[PSF_VOUT_OV_WARN] | detail.vout[PSF_VOUT_UV_WARN]
         | detail.vout[PSF_VOUT_TONMAX] | detail.input_st[PSF_INPUT_LOW]
         | detail.vout[PSF_VOUT_LIM] | detail.bandgap_overtemp_flag
         | detail.internal_supply_flag;
      sum_byte = {1'b0, bb.converter_off, bb.overvoltage_fault_flag,
         bb.overcurrent_fault_flag, 1'b0, bb.temperature_alarm_flag,
         bb.comm_logic_fault_flag, bb.other_flag};
      png_now = ~power_good;
      sum_hi = {|detail.vout[PSF_VOUT_OV_FAULT:PSF_VOUT_TONMAX],
         detail.iout[PSF_IOUT_OC_FAULT] | detail.iout[PSF_IOUT_OC_WARN],
         |detail.input_st,
         detail.bandgap_overtemp_flag | detail.internal_supply_flag,
         png_now, 3'h0};
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   logic hit_fall;
   logic hit_byte;
   logic hit_word;
   logic refuse;
   logic png_evt;
   logic low_evt;
   logic src_evt;

   always_comb begin
      next_st = st;
      hit_fall = cmd.valid && (cmd.code == PSF_CMD_FALL_TIME);
      hit_byte = cmd.valid && (cmd.code == PSF_CMD_SUM_BYTE);
      hit_word = cmd.valid && (cmd.code == PSF_CMD_SUM_WORD);
      refuse = (hit_fall && loop_slave) || ((hit_byte || hit_word) && cmd.write);
      next_st.resp.valid = cmd.valid;
      next_st.resp.ack = 1'b0;
      next_st.resp.rdata = 16'h0000;
      if (hit_fall && !loop_slave) begin
         next_st.resp.ack = 1'b1;
         if (cmd.write) begin
            next_st.mant = cmd.wdata[PSF_MANT_W-1:0];
         end else begin
            next_st.resp.rdata = fall_word(st.mant);
         end
      end else if (hit_byte && !cmd.write) begin
         next_st.resp.ack = 1'b1;
         next_st.resp.rdata = {8'h00, sum_byte};
      end else if (hit_word && !cmd.write) begin
         next_st.resp.ack = 1'b1;
         next_st.resp.rdata = {sum_hi, sum_byte};
      end
      next_st.bad_cmd = refuse;
      next_st.eff_ms = quantise(st.mant);
      next_st.nv_valid = store_all;
      if (store_all) begin
         next_st.nv_word = fall_word(st.mant);
      end
      if (png_mask_wr) begin
         next_st.png_mask = png_mask_val;
      end
      if (power_good) begin
         next_st.pg_seen = 1'b1;
      end
      next_st.png_prev = png_now;
      png_evt = png_now && !st.png_prev && st.pg_seen && !st.png_mask;
      if (vin_above_on) begin
         next_st.vin_seen = 1'b1;
      end
      next_st.below_prev = vin_below_off;
      low_evt = vin_below_off && !st.below_prev && st.vin_seen;
      next_st.src_prev = src_alert;
      src_evt = src_alert && !st.src_prev; // arrives already masked
      next_st.alert = refuse || png_evt || low_evt || src_evt;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.mant <= PSF_MANT_RESET;
         // the reset mantissa is its own bucket, so no lookup is needed here
         st.eff_ms <= PSF_MANT_RESET;
         st.png_mask <= PSF_PNG_MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign resp = st.resp;
   assign nv_store_valid = st.nv_valid;
   assign nv_fall_time = st.nv_word;
   assign invalid_command_fault = st.bad_cmd;
   assign alert_event = st.alert;
   assign eff_fall_ms = st.eff_ms;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_slave_fall;
      cmd.valid && cmd.code == PSF_CMD_FALL_TIME && loop_slave;
   endsequence
   sequence s_nack_fault;
      resp.valid && !resp.ack && invalid_command_fault && alert_event;
   endsequence

   a_slave_refused: assert property (s_slave_fall |=> s_nack_fault)
      else $error("loop slave fall-time access not refused");
   a_slave_nowrite: assert property (s_slave_fall and cmd.write |=> $stable(st.mant))
      else $error("loop slave write changed fall time");
   a_fall_read_fmt: assert property (resp.valid && resp.ack && $past(hit_fall)
      |-> resp.rdata[15:PSF_MANT_W] == '0)
      else $error("fall-time fixed bits not zero");
   a_low_byte_same: assert property (cmd.valid && !cmd.write && cmd.code == PSF_CMD_SUM_WORD
      |=> resp.rdata[7:0] == $past(sum_byte))
      else $error("word low byte differs from byte");
   a_off_bit: assert property (!converter_enabled && hit_byte && !cmd.write
      |=> resp.rdata[6])
      else $error("converter-off bit not set");
   a_store_copy: assert property (store_all |=> nv_store_valid
      && nv_fall_time[PSF_MANT_W-1:0] == $past(st.mant))
      else $error("store did not copy fall time");
   a_quant_track: assert property (st.mant == 7'h00 ##1 st.mant == 7'h00
      |-> eff_fall_ms == 7'h01)
      else $error("zero fall time not 1 ms");
   a_quant_top: assert property ($stable(st.mant) && st.mant > 7'h56
      |=> eff_fall_ms == 7'h64)
      else $error("large fall time not 100 ms");
   a_no_pg_alert: assert property (!st.pg_seen && !refuse && !low_evt && !src_evt
      |=> !alert_event)
      else $error("alert before first power good");
   a_ov_slave: assert property (loop_slave |-> sum_byte[5] == 1'b0)
      else $error("loop slave overvoltage bit set");

endmodule
`default_nettype wire

// >>> psf_regs_tb.sv
// self-checking bench of the status summary and fall-time registers
`default_nettype none
module psf_regs_tb
   import psf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   psf_cmd_t cmd;
   psf_resp_t resp;
   psf_detail_t detail = {16'h0, 8'h08, 18'h0};
   logic loop_slave = 1'h0, converter_enabled = 1'h1, power_good = 1'h0, src_alert = 1'h0;
   logic vin_above_on = 1'h0, vin_below_off = 1'h0, png_mask_wr = 1'h0, png_mask_val = 1'h1;
   logic store_all = 1'h0, nv_store_valid, invalid_command_fault, alert_event;
   logic [1:0] ack;
   logic [15:0] nv_fall_time, rd;
   logic [6:0] eff_fall_ms;
   int err_total = 0, samples_checked = 0, cycles = 0;
   always #4 sys_clk = ~sys_clk;
   psf_regs psf_regs_i (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .resp(resp),
      .loop_slave(loop_slave), .converter_enabled(converter_enabled),
      .power_good(power_good), .detail(detail), .src_alert(src_alert),
      .vin_above_on(vin_above_on), .vin_below_off(vin_below_off),
      .png_mask_wr(png_mask_wr), .png_mask_val(png_mask_val), .store_all(store_all),
      .nv_store_valid(nv_store_valid), .nv_fall_time(nv_fall_time),
      .invalid_command_fault(invalid_command_fault), .alert_event(alert_event),
      .eff_fall_ms(eff_fall_ms));
   psf_host psf_host_i (.sys_clk(sys_clk), .cmd(cmd), .resp(resp));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic xf(input logic wr, input logic [7:0] code, input logic [15:0] wd);
      psf_host_i.xfer(wr, code, wd, ack, rd);
   endtask
   function automatic logic [15:0] flags();
      return {12'h0, ack, invalid_command_fault, alert_event};
   endfunction
   function automatic logic [15:0] exp_word(psf_detail_t d, logic en, logic pg, logic ls);
      logic m;
      m = d.bandgap_overtemp_flag | d.internal_supply_flag;
      return {|d.vout[7:2], d.iout[7] | d.iout[5], |d.input_st, m, ~pg, 3'h0,
         1'h0, ~en, d.vout[7] & ~ls, d.iout[7], 1'h0, d.temp[7] | d.temp[6], |d.comm,
         |d.vout[6:2] | d.iout[5] | d.input_st[3] | m};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check({9'h0, eff_fall_ms}, 16'h0003);
      xf(1'h0, PSF_CMD_FALL_TIME, 16'h0000);
      check(rd, 16'h0003);
      xf(1'h0, PSF_CMD_SUM_WORD, 16'h0000);
      check(rd, exp_word(detail, 1'h1, 1'h0, 1'h0));
   endtask
   task automatic t_fall();
      int m[22] = '{0, 1, 2, 6, 7, 9, 10, 12, 13, 17, 18, 22, 23, 32, 33, 44, 45, 62, 63,
         86, 87, 127};
      int e[22] = '{1, 1, 2, 6, 7, 7, 10, 10, 14, 14, 19, 19, 27, 27, 37, 37, 52, 52, 72,
         72, 100, 100};
      for (int i = 0; i < 22; i++) begin
         xf(1'h1, PSF_CMD_FALL_TIME, 16'hFF80 | 16'(m[i]));
         check(flags(), 16'h000C);
         repeat (2) @(posedge sys_clk);
         check({9'h0, eff_fall_ms}, 16'(e[i]));
         xf(1'h0, PSF_CMD_FALL_TIME, 16'h0000);
         check(rd, 16'(m[i]));
      end
   endtask
   task automatic t_store();
      @(posedge sys_clk);
      store_all <= 1'h1;
      @(posedge sys_clk);
      store_all <= 1'h0;
      @(posedge sys_clk);
      check({nv_store_valid, nv_fall_time[14:0]}, 16'h807F);
      check(nv_fall_time, 16'h007F);
   endtask
   task automatic t_slave();
      psf_detail_t d;
      d = detail;
      d.vout = 8'h80;
      detail <= d;
      loop_slave <= 1'h1;
      xf(1'h1, PSF_CMD_FALL_TIME, 16'h0005);
      check(flags(), 16'h000B);
      xf(1'h0, PSF_CMD_FALL_TIME, 16'h0000);
      check(flags(), 16'h000B);
      check(rd, 16'h0000);
      xf(1'h0, PSF_CMD_SUM_WORD, 16'h0000);
      check(rd, exp_word(d, 1'h1, 1'h0, 1'h1));
      loop_slave <= 1'h0;
      xf(1'h0, PSF_CMD_FALL_TIME, 16'h0000);
      check(rd, 16'h007F);
   endtask
   task automatic edge_alert(input int sel, input logic v, input logic exp);
      @(posedge sys_clk);
      case (sel)
         0: src_alert <= v;
         1: power_good <= v;
         2: vin_below_off <= v;
         default: vin_above_on <= v;
      endcase
      repeat (2) @(posedge sys_clk);
      check({15'h0, alert_event}, {15'h0, exp});
   endtask
   task automatic t_alert();
      edge_alert(0, 1'h1, 1'h1);
      edge_alert(0, 1'h0, 1'h0);
      edge_alert(1, 1'h1, 1'h0);
      edge_alert(1, 1'h0, 1'h0);
      png_mask_val <= 1'h0;
      png_mask_wr <= 1'h1;
      @(posedge sys_clk);
      png_mask_wr <= 1'h0;
      edge_alert(1, 1'h1, 1'h0);
      edge_alert(1, 1'h0, 1'h1);
      edge_alert(2, 1'h1, 1'h0);
      edge_alert(2, 1'h0, 1'h0);
      edge_alert(3, 1'h1, 1'h0);
      edge_alert(2, 1'h1, 1'h1);
   endtask
   task automatic t_sum();
      psf_detail_t d;
      logic [15:0] w;
      for (int i = 0; i < 42; i++) begin
         d = psf_detail_t'(42'h1 << i);
         detail <= d;
         converter_enabled <= i[0];
         power_good <= i[1];
         w = exp_word(d, i[0], i[1], 1'h0);
         xf(1'h0, PSF_CMD_SUM_WORD, 16'h0000);
         check(rd, w);
         xf(1'h0, PSF_CMD_SUM_BYTE, 16'h0000);
         check(rd, {8'h00, w[7:0]});
      end
      xf(1'h1, PSF_CMD_SUM_WORD, 16'h0000);
      check(flags(), 16'h000B);
      xf(1'h1, PSF_CMD_SUM_BYTE, 16'h00FF);
      check(flags(), 16'h000B);
      xf(1'h0, PSF_CMD_SUM_WORD, 16'h0000);
      check(rd, w);
      xf(1'h0, PSF_CMD_FALL_TIME + 8'h01, 16'h0000);
      check(flags(), 16'h0008);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      t_reset();
      t_fall();
      t_store();
      t_slave();
      t_alert();
      t_sum();
      rst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
